// >>> design/dsc_pkg.sv
// Shared constants and carrier types for the deserializer config registers
package dsc_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Register indices; byte address is four times the index
  localparam logic [5:0] DSC_IDX_GEN_CFG_ONE = 6'h03;
  localparam logic [5:0] DSC_IDX_LINK_WDOG = 6'h04;
  localparam logic [5:0] DSC_IDX_SBUS_CTL_ONE = 6'h05;
  localparam logic [5:0] DSC_IDX_SBUS_CTL_TWO = 6'h06;

  // Reset values
  localparam logic [7:0] DSC_RST_GEN_CFG_ONE = 8'h70;
  localparam logic [7:0] DSC_RST_LINK_WDOG = 8'hfe;
  localparam logic [7:0] DSC_RST_SBUS_CTL_ONE = 8'h1e;
  localparam logic [7:0] DSC_RST_SBUS_CTL_TWO = 8'h00;

  // Writable bit masks; cleared bits are reserved
  localparam logic [7:0] DSC_WMASK_GEN_CFG_ONE = 8'h7e;
  localparam logic [7:0] DSC_WMASK_LINK_WDOG = 8'hff;
  localparam logic [7:0] DSC_WMASK_SBUS_CTL_ONE = 8'hff;

  ////////////////////////////////////////////////////////////////////////////
  // Field positions of general_config_one
  localparam int DSC_BIT_CHECKSUM_GEN = 6;
  localparam int DSC_BIT_PULL_SELECT = 5;
  localparam int DSC_BIT_SYNC_FILTER = 4;
  localparam int DSC_BIT_MATCH_FWD = 3;
  localparam int DSC_BIT_AUTO_ACK = 2;
  localparam int DSC_BIT_COLOUR_GATE = 1;
  // Field positions of control_link_watchdog
  localparam int DSC_WDOG_TIME_MSB = 7;
  localparam int DSC_WDOG_TIME_LSB = 1;
  localparam int DSC_BIT_WDOG_OFF = 0;
  // Field positions of serial_bus_control_one
  localparam int DSC_BIT_FWD_ALL = 7;
  localparam int DSC_HOLD_MSB = 6;
  localparam int DSC_HOLD_LSB = 4;
  localparam int DSC_GLITCH_MSB = 3;
  localparam int DSC_GLITCH_LSB = 0;

  ////////////////////////////////////////////////////////////////////////////
  // Timing
  localparam int DSC_CLK_HZ = 40000000;
  localparam int DSC_WDOG_STEP_MS = 2;
  localparam int DSC_WDOG_STEP_CYCLES = DSC_CLK_HZ / 1000 * DSC_WDOG_STEP_MS;
  localparam int DSC_HOLD_STEP_NS = 50;
  localparam int DSC_GLITCH_STEP_NS = 5;
  // Sync pulse filter lengths in clocks
  localparam logic [2:0] DSC_FILT_LEN_NORMAL = 3'h2;
  localparam logic [2:0] DSC_FILT_LEN_DUAL = 3'h4;
  localparam logic [2:0] DSC_FILT_LEN_OFF = 3'h1;

  ////////////////////////////////////////////////////////////////////////////
  // Carriers
  typedef struct packed {
    logic checksum_gen_on;
    logic pull_select;
    logic match_forward;
    logic auto_ack;
    logic forward_all;
    logic [2:0] sda_hold;
    logic [3:0] glitch_depth;
  } dsc_cfg_t;

  typedef struct packed {
    logic active_video_flag;
    logic line_sync;
    logic frame_sync;
  } dsc_sync_t;

endpackage

// >>> design/dsc_pulse_filter.sv
// Short pulse rejection filter for one sync line
`timescale 1ns/1ps
module dsc_pulse_filter (
  // Clock and reset
  input wire logic clk_in,
  input wire logic sys_rst_in,
  // Control
  input wire logic [2:0] min_len_in,
  // Data
  input wire logic raw_in,
  output logic clean_out
);
  import dsc_pkg::*;

  logic clean_q;
  logic clean_d;
  logic [2:0] run_q;
  logic [2:0] run_d;
  wire differs = raw_in != clean_q;
  wire long_enough = (run_q + 3'h1) >= min_len_in;

  // A new level is taken only after it held for min_len_in clocks
  always_comb begin
    clean_d = clean_q;
    run_d = 3'h0;
    if (differs) begin
      if (long_enough) begin
        clean_d = raw_in;
      end else begin
        run_d = run_q + 3'h1;
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      clean_q <= 1'b0;
      run_q <= 3'h0;
    end else begin
      clean_q <= clean_d;
      run_q <= run_d;
    end
  end

  assign clean_out = clean_q;

endmodule // dsc_pulse_filter

// >>> design/dsc_config_regs.sv
// Deserializer general and serial bus configuration registers
//
// Design decision made here: the Avalon-MM interface to the registers.
`timescale 1ns/1ps
module dsc_config_regs #(
  parameter int unsigned WDOG_STEP_CYC = dsc_pkg::DSC_WDOG_STEP_CYCLES
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic sys_rst_in,
  // Avalon-MM slave
  input wire logic [7:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  input wire logic [3:0] avs_byteenable_in,
  output logic [31:0] avs_readdata_out,
  output logic avs_waitrequest_out,
  // Configuration to the consuming logic
  output dsc_pkg::dsc_cfg_t cfg_out,
  // Link status
  input wire logic dual_lane_in,
  input wire logic ser_protected_in,
  // Video path
  input wire dsc_pkg::dsc_sync_t sync_in,
  input wire logic [23:0] colour_in,
  output dsc_pkg::dsc_sync_t sync_out,
  output logic [23:0] colour_out,
  // Control link watchdog
  input wire logic link_busy_in,
  output logic link_abort_out
);
  import dsc_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Helpers
  function automatic logic [7:0] merge_write(input logic [7:0] old_val,
                                             input logic [7:0] new_val,
                                             input logic [7:0] mask);
    merge_write = (old_val & ~mask) | (new_val & mask);
  endfunction

  // Consumer fields from the two register values; also gives the reset view
  function automatic dsc_cfg_t cfg_of(input logic [7:0] gen,
                                      input logic [7:0] sbus);
    dsc_cfg_t c;
    c.checksum_gen_on = gen[DSC_BIT_CHECKSUM_GEN];
    c.pull_select = gen[DSC_BIT_PULL_SELECT];
    c.match_forward = gen[DSC_BIT_MATCH_FWD];
    c.auto_ack = gen[DSC_BIT_AUTO_ACK];
    c.forward_all = sbus[DSC_BIT_FWD_ALL];
    c.sda_hold = sbus[DSC_HOLD_MSB:DSC_HOLD_LSB];
    c.glitch_depth = sbus[DSC_GLITCH_MSB:DSC_GLITCH_LSB];
    return c;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Bus slave: one wait cycle, then the access completes
  logic wait_q;
  logic [31:0] rdata_q;
  logic [7:0] gen_cfg_q;
  logic [7:0] wdog_q;
  logic [7:0] sbus_one_q;

  wire req = avs_read_in | avs_write_in;
  wire accept = req & ~wait_q;
  wire word_ok = avs_address_in[1:0] == 2'h0;
  wire [5:0] idx = avs_address_in[7:2];
  wire lane0 = avs_write_in & accept & word_ok & avs_byteenable_in[0];
  wire wr_gen = lane0 & (idx == DSC_IDX_GEN_CFG_ONE);
  wire wr_wdog = lane0 & (idx == DSC_IDX_LINK_WDOG);
  wire wr_sbus_one = lane0 & (idx == DSC_IDX_SBUS_CTL_ONE);
  wire [7:0] wbyte = avs_writedata_in[7:0];

  // Unmapped and misaligned reads return zero
  wire [7:0] rd_byte =
    !word_ok ? 8'h00 :
    (idx == DSC_IDX_GEN_CFG_ONE) ? gen_cfg_q :
    (idx == DSC_IDX_LINK_WDOG) ? wdog_q :
    (idx == DSC_IDX_SBUS_CTL_ONE) ? sbus_one_q :
    (idx == DSC_IDX_SBUS_CTL_TWO) ? DSC_RST_SBUS_CTL_TWO : 8'h00;

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      wait_q <= 1'b1;
      rdata_q <= 32'h0;
    end else begin
      wait_q <= ~(req & wait_q);
      if (req & wait_q) begin
        rdata_q <= {24'h0, rd_byte};
      end
    end
  end

  assign avs_waitrequest_out = wait_q;
  assign avs_readdata_out = rdata_q;

  ////////////////////////////////////////////////////////////////////////////
  // Register storage
  wire [7:0] gen_cfg_d = wr_gen ?
    merge_write(gen_cfg_q, wbyte, DSC_WMASK_GEN_CFG_ONE) : gen_cfg_q;
  wire [7:0] wdog_d = wr_wdog ?
    merge_write(wdog_q, wbyte, DSC_WMASK_LINK_WDOG) : wdog_q;
  wire [7:0] sbus_one_d = wr_sbus_one ?
    merge_write(sbus_one_q, wbyte, DSC_WMASK_SBUS_CTL_ONE) : sbus_one_q;

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      gen_cfg_q <= DSC_RST_GEN_CFG_ONE;
      wdog_q <= DSC_RST_LINK_WDOG;
      sbus_one_q <= DSC_RST_SBUS_CTL_ONE;
    end else begin
      gen_cfg_q <= gen_cfg_d;
      wdog_q <= wdog_d;
      sbus_one_q <= sbus_one_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Configuration outputs
  dsc_cfg_t cfg_q;
  dsc_cfg_t cfg_d;

  assign cfg_d = cfg_of(gen_cfg_d, sbus_one_d);

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      // Consumers see the reset settings while reset is held
      cfg_q <= cfg_of(DSC_RST_GEN_CFG_ONE, DSC_RST_SBUS_CTL_ONE);
    end else begin
      cfg_q <= cfg_d;
    end
  end

  assign cfg_out = cfg_q;

  ////////////////////////////////////////////////////////////////////////////
  // Sync filters
  wire filt_on = gen_cfg_q[DSC_BIT_SYNC_FILTER];
  wire [2:0] len_std = filt_on ? DSC_FILT_LEN_NORMAL : DSC_FILT_LEN_OFF;
  wire [2:0] len_line = !filt_on ? DSC_FILT_LEN_OFF :
    dual_lane_in ? DSC_FILT_LEN_DUAL : DSC_FILT_LEN_NORMAL;
  dsc_sync_t sync_clean;

  dsc_pulse_filter u_flag_filter (
    .clk_in(clk_in),
    .sys_rst_in(sys_rst_in),
    .min_len_in(len_std),
    .raw_in(sync_in.active_video_flag),
    .clean_out(sync_clean.active_video_flag)
  );

  dsc_pulse_filter u_line_filter (
    .clk_in(clk_in),
    .sys_rst_in(sys_rst_in),
    .min_len_in(len_line),
    .raw_in(sync_in.line_sync),
    .clean_out(sync_clean.line_sync)
  );

  dsc_pulse_filter u_frame_filter (
    .clk_in(clk_in),
    .sys_rst_in(sys_rst_in),
    .min_len_in(len_std),
    .raw_in(sync_in.frame_sync),
    .clean_out(sync_clean.frame_sync)
  );

  assign sync_out = sync_clean;

  ////////////////////////////////////////////////////////////////////////////
  // Colour gating by the active video flag
  logic [23:0] colour_q;
  wire gate_on = ser_protected_in | gen_cfg_q[DSC_BIT_COLOUR_GATE];
  wire [23:0] colour_d =
    (gate_on & ~sync_clean.active_video_flag) ? 24'h0 : colour_in;

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      colour_q <= 24'h0;
    end else begin
      colour_q <= colour_d;
    end
  end

  assign colour_out = colour_q;

  ////////////////////////////////////////////////////////////////////////////
  // Control link watchdog
  logic [31:0] pre_q;
  logic [6:0] step_q;
  logic done_q;
  logic abort_q;
  wire [6:0] wdog_time = wdog_q[DSC_WDOG_TIME_MSB:DSC_WDOG_TIME_LSB];
  wire wdog_off = wdog_q[DSC_BIT_WDOG_OFF];
  wire step_end = pre_q == (WDOG_STEP_CYC - 32'h1);
  wire fire = link_busy_in & ~wdog_off & ~done_q &
    (step_q >= wdog_time);
  // A zero timeout aborts at once, which is why software avoids it
  wire [31:0] pre_d = (!link_busy_in | step_end) ? 32'h0 : pre_q + 32'h1;
  wire [6:0] step_d = !link_busy_in ? 7'h0 :
    (step_end && step_q != 7'h7f) ? step_q + 7'h1 : step_q;

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      pre_q <= 32'h0;
      step_q <= 7'h0;
      done_q <= 1'b0;
      abort_q <= 1'b0;
    end else begin
      pre_q <= pre_d;
      step_q <= step_d;
      done_q <= link_busy_in & (done_q | fire);
      abort_q <= fire;
    end
  end

  assign link_abort_out = abort_q;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  logic [31:0] busy_len_q;

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      busy_len_q <= 32'h0;
    end else begin
      busy_len_q <= link_busy_in ? busy_len_q + 32'h1 : 32'h0;
    end
  end

  a_bus_one_wait: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    $rose(req) |-> wait_q ##1 !wait_q)
    else $error("Bus access did not complete after one wait cycle");

  a_checksum_gen_write: assert property (@(posedge clk_in)
    disable iff (sys_rst_in)
    wr_gen |-> ##1 cfg_out.checksum_gen_on == $past(wbyte[6]))
    else $error("Checksum generator enable did not follow write");

  a_pull_select_write: assert property (@(posedge clk_in)
    disable iff (sys_rst_in)
    wr_gen |-> ##1 cfg_out.pull_select == $past(wbyte[5]))
    else $error("Pull select did not follow write");

  a_flag_short_reject: assert property (@(posedge clk_in)
    disable iff (sys_rst_in)
    $rose(sync_out.active_video_flag) && $past(filt_on) |->
      $past(sync_in.active_video_flag) &&
      $past(sync_in.active_video_flag, 2))
    else $error("Active video pulse under two clocks passed");

  a_line_dual_reject: assert property (@(posedge clk_in)
    disable iff (sys_rst_in)
    $rose(sync_out.line_sync) && $past(filt_on) && $past(dual_lane_in) |->
      $past(sync_in.line_sync) && $past(sync_in.line_sync, 2) &&
      $past(sync_in.line_sync, 3) && $past(sync_in.line_sync, 4))
    else $error("Dual-lane line sync pulse under four clocks passed");

  a_forward_modes: assert property (@(posedge clk_in)
    disable iff (sys_rst_in)
    wr_gen ##1 !wr_sbus_one && !wr_gen |-> ##1
      cfg_out.match_forward == $past(wbyte[3], 2) &&
      cfg_out.auto_ack == $past(wbyte[2], 2))
    else $error("Forwarding controls did not follow write");

  a_colour_gated: assert property (@(posedge clk_in)
    disable iff (sys_rst_in)
    gate_on && !sync_out.active_video_flag |=> colour_out == 24'h0)
    else $error("Colour passed outside active video while gated");

  a_colour_ungated: assert property (@(posedge clk_in)
    disable iff (sys_rst_in)
    !ser_protected_in && !gen_cfg_q[DSC_BIT_COLOUR_GATE] |=>
      colour_out == $past(colour_in))
    else $error("Colour gated while gating is off");

  a_wdog_period: assert property (@(posedge clk_in)
    disable iff (sys_rst_in)
    $rose(link_abort_out) && $stable(wdog_time) |->
      busy_len_q == 32'(wdog_time) * WDOG_STEP_CYC + 32'h1)
    else $error("Watchdog abort at wrong time");

  a_wdog_disabled: assert property (@(posedge clk_in)
    disable iff (sys_rst_in)
    $past(wdog_off) |-> !$rose(link_abort_out))
    else $error("Watchdog aborted while disabled");

  a_sbus_fields: assert property (@(posedge clk_in)
    disable iff (sys_rst_in)
    wr_sbus_one |=> cfg_out.sda_hold == $past(wbyte[6:4]) &&
      cfg_out.glitch_depth == $past(wbyte[3:0]) &&
      cfg_out.forward_all == $past(wbyte[7]))
    else $error("Serial bus fields did not follow write");

  a_reserved_zero: assert property (@(posedge clk_in)
    disable iff (sys_rst_in)
    avs_read_in && wait_q && word_ok && idx == DSC_IDX_GEN_CFG_ONE |=>
      avs_readdata_out[31:7] == 25'h0 && avs_readdata_out[0] == 1'b0)
    else $error("Reserved bits read non-zero");

endmodule // dsc_config_regs

// >>> testbench/dsc_config_regs_tb.sv
// Self-checking testbench for the deserializer configuration registers
`timescale 1ns/1ps
module dsc_config_regs_tb;
  import dsc_pkg::*;
  localparam int unsigned STEP = 4;
  logic clk_in, sys_rst_in;
  logic [7:0] avs_address;
  logic avs_read, avs_write;
  logic [31:0] avs_writedata, avs_readdata;
  logic [3:0] avs_byteenable;
  logic avs_waitrequest;
  dsc_cfg_t cfg;
  logic dual_lane, ser_protected, link_busy, link_abort;
  dsc_sync_t sync_in, sync_out;
  logic [23:0] colour_in, colour_out;
  int miscompares = 0;
  int total_checks = 0;

  dsc_config_regs #(.WDOG_STEP_CYC(STEP)) u_dut (
    .clk_in(clk_in), .sys_rst_in(sys_rst_in),
    .avs_address_in(avs_address), .avs_read_in(avs_read),
    .avs_write_in(avs_write), .avs_writedata_in(avs_writedata),
    .avs_byteenable_in(avs_byteenable), .avs_readdata_out(avs_readdata),
    .avs_waitrequest_out(avs_waitrequest), .cfg_out(cfg),
    .dual_lane_in(dual_lane), .ser_protected_in(ser_protected),
    .sync_in(sync_in), .colour_in(colour_in), .sync_out(sync_out),
    .colour_out(colour_out), .link_busy_in(link_busy),
    .link_abort_out(link_abort)
  );

  initial begin
    clk_in = 1'b0;
    forever #12.5 clk_in = ~clk_in;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input string name, input logic [31:0] exp,
                       input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask

  // One Avalon access; holds the request until waitrequest is sampled low
  task automatic bus_op(input logic wr, input logic [7:0] addr,
                        input logic [7:0] data, input logic be,
                        output logic [31:0] rdata);
    int n;
    n = 0;
    @(posedge clk_in);
    avs_address <= addr;
    avs_writedata <= {24'h000000, data};
    avs_byteenable <= {3'h0, be};
    avs_write <= wr;
    avs_read <= ~wr;
    do begin
      @(posedge clk_in);
      n++;
    end while (avs_waitrequest !== 1'b0);
    rdata = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    check("bus answer", 1'b1, n < 20);
  endtask

  task automatic wr(input logic [7:0] addr, input logic [7:0] data);
    logic [31:0] d;
    bus_op(1'b1, addr, data, 1'b1, d);
  endtask

  task automatic rd_check(input logic [7:0] addr, input logic [7:0] exp);
    logic [31:0] d;
    bus_op(1'b0, addr, 8'h00, 1'b1, d);
    check($sformatf("read %h", addr), {24'h000000, exp}, d);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic test_reset_values();
    rd_check(8'h0c, 8'h70);
    rd_check(8'h10, 8'hfe);
    rd_check(8'h14, 8'h1e);
    rd_check(8'h18, 8'h00);
    rd_check(8'h40, 8'h00);
    check("cfg reset", {1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 3'h1, 4'he}, cfg);
  endtask

  task automatic test_write_fields();
    logic [31:0] d;
    wr(8'h0c, 8'hff);
    rd_check(8'h0c, 8'h7e);
    check("cfg gen", 4'hf, {cfg.checksum_gen_on, cfg.pull_select,
      cfg.match_forward, cfg.auto_ack});
    wr(8'h0c, 8'h00);
    @(posedge clk_in);
    check("cfg gen off", 4'h0, {cfg.checksum_gen_on, cfg.pull_select,
      cfg.match_forward, cfg.auto_ack});
    bus_op(1'b1, 8'h0c, 8'h7e, 1'b0, d);
    rd_check(8'h0c, 8'h00);
    wr(8'h14, 8'ha5);
    rd_check(8'h14, 8'ha5);
    check("cfg sbus", {1'b1, 3'h2, 4'h5}, {cfg.forward_all, cfg.sda_hold,
      cfg.glitch_depth});
    wr(8'h18, 8'hff);
    rd_check(8'h18, 8'h00);
  endtask

  // Pulse one sync line for len clocks and report whether it came through
  task automatic pulse(input int fld, input int len, input logic exp);
    logic seen;
    seen = 1'b0;
    @(posedge clk_in);
    sync_in <= dsc_sync_t'(3'b001 << fld);
    for (int i = 0; i < len + 8; i++) begin
      @(posedge clk_in);
      if (i == len - 1)
        sync_in <= '0;
      #1;
      if (sync_out[fld] === 1'b1)
        seen = 1'b1;
    end
    check($sformatf("sync %0d len %0d", fld, len), exp, seen);
  endtask

  task automatic test_filter();
    wr(8'h0c, 8'h10);
    for (int f = 0; f < 3; f++) begin
      pulse(f, 1, 1'b0);
      pulse(f, 3, 1'b1);
    end
    @(posedge clk_in);
    dual_lane <= 1'b1;
    pulse(1, 3, 1'b0);
    pulse(1, 5, 1'b1);
    pulse(0, 3, 1'b1);
    @(posedge clk_in);
    dual_lane <= 1'b0;
    wr(8'h0c, 8'h00);
    pulse(0, 1, 1'b1);
  endtask

  task automatic colour_case(input logic prot, input logic gate,
                             input logic flag, input logic [23:0] exp);
    wr(8'h0c, {6'h00, gate, 1'b0});
    ser_protected <= prot;
    sync_in <= dsc_sync_t'({flag, 2'b00});
    colour_in <= 24'h5a3c96;
    repeat (8) @(posedge clk_in);
    check("colour", exp, colour_out);
  endtask

  task automatic test_colour();
    colour_case(1'b0, 1'b0, 1'b0, 24'h5a3c96);
    colour_case(1'b0, 1'b1, 1'b0, 24'h000000);
    colour_case(1'b1, 1'b0, 1'b0, 24'h000000);
    colour_case(1'b0, 1'b1, 1'b1, 24'h5a3c96);
    sync_in <= '0;
    ser_protected <= 1'b0;
  endtask

  // Busy for 41 clocks; returns the number of aborts in the first 40 and the first one's cycle
  task automatic busy_run(output int pulses, output int first);
    pulses = 0;
    first = 0;
    @(posedge clk_in);
    link_busy <= 1'b1;
    for (int i = 1; i <= 40; i++) begin
      @(posedge clk_in);
      #1;
      if (link_abort === 1'b1) begin
        if (pulses == 0)
          first = i;
        pulses++;
      end
    end
    @(posedge clk_in);
    link_busy <= 1'b0;
    repeat (3) @(posedge clk_in);
  endtask

  task automatic test_watchdog();
    int p, f;
    wr(8'h10, 8'h04);
    busy_run(p, f);
    check("abort count", 32'd1, p);
    check("abort time", 1'b1, f >= 2 * STEP + 1 && f <= 2 * STEP + 3);
    wr(8'h10, 8'h06);
    busy_run(p, f);
    check("abort count", 32'd1, p);
    check("abort time", 1'b1, f >= 3 * STEP + 1 && f <= 3 * STEP + 3);
    wr(8'h10, 8'h05);
    busy_run(p, f);
    check("abort disabled", 32'd0, p);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  initial begin
    #(25 * 20000);
    miscompares++;
    print_verdict();
  end

  initial begin
    sys_rst_in = 1'b1;
    avs_address = 8'h00;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h00000000;
    avs_byteenable = 4'h0;
    dual_lane = 1'b0;
    ser_protected = 1'b0;
    link_busy = 1'b0;
    sync_in = '0;
    colour_in = 24'h000000;
    repeat (20) @(posedge clk_in);
    check("cfg in reset", {1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 3'h1, 4'he}, cfg);
    sys_rst_in <= 1'b0;
    repeat (2) @(posedge clk_in);
    test_reset_values();
    test_write_fields();
    test_filter();
    test_colour();
    test_watchdog();
    print_verdict();
  end
endmodule // dsc_config_regs_tb
